// file: shared/frsr_pkg.sv
// Overview of operation
// R1 - input register at 3F7 is read only
// R2 - AT mode: bits 0 to 6 read zero
// R3 - bit 7: inverted change pin or forced value
// R4 - second-gen bit 0 low at fast rates
// R5 - rate bits survive soft reset, hard reset 250K
// R6 - second-gen bits 3-6 ones, 1-2 rate
// R7 - model-30 bit 2 precomp, bits 0-1 rate
// R8 - model-30 bit 3 mirrors transfer gate
// R9 - model-30 bits 4-6 zero, reset value 0x02
// R10 - write 3F7 loads rate bits, reset 10
// R11 - host writes zero to reserved bits
// R12 - model-30 bit 2 stored, survives soft reset
// R13 - density pin high on hard reset only; the code also drives it high after a write of 500K or 1M
// R14 - status bytes returned in result phase
// R15 - status0 bits 7:6 termination code
// R16 - status0 bit 5 positioning done
// R17 - status0 bit 4 drive fault
// R18 - status0 bit 3 always zero
// R19 - status0 bit 2 head, bits 1:0 unit
// R20 - external mode input selects read layout
// R21 - rate codes 00 500K 01 300K 10 250K 11 1M
package frsr_pkg;
    localparam logic [9:0] ADDR_INPUT_CONFIG = 10'h3F7;
    localparam logic [9:0] ADDR_DATA         = 10'h3F5;
    localparam logic [1:0] RATE_500K         = 2'h0;
    localparam logic [1:0] RATE_300K         = 2'h1;
    localparam logic [1:0] RATE_250K         = 2'h2;
    localparam logic [1:0] RATE_1M           = 2'h3;
    localparam logic [1:0] RATE_RESET        = RATE_250K;
    localparam logic       DENSITY_RESET     = 1'h1;
    localparam logic       PRECOMP_RESET     = 1'h0;
    localparam int         BIT_CHANGE        = 7;
    localparam int         BIT_GATE          = 3;
    localparam int         BIT_PRECOMP       = 2;
    localparam int         BIT_SECOND_RATE   = 1;
    localparam logic [3:0] SECOND_GEN_ONES   = 4'hF;
    localparam int         RECAL_STEP_LIMIT  = 80;
    localparam logic [1:0] TERM_NORMAL       = 2'h0;
    localparam logic [1:0] TERM_ABNORMAL     = 2'h1;
    localparam logic [1:0] TERM_INVALID      = 2'h2;
    localparam logic [1:0] TERM_POLLING      = 2'h3;
    localparam logic [7:0] READ_IDLE         = 8'h00;
    typedef enum logic [1:0] {
        FRSR_MODE_AT,
        FRSR_MODE_SECOND_GEN,
        FRSR_MODE_MODEL30,
        FRSR_MODE_SPARE
    } frsr_mode_t;
endpackage : frsr_pkg

// file: design/frsr_sync.sv
`timescale 1ns/100ps
// two-flop synchroniser for cable pins
module frsr_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clock,
    input  wire logic             i_resetn,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= i_async;
            sync_ff <= meta_ff;
        end
    end

    assign o_sync = sync_ff;
endmodule : frsr_sync

// file: design/frsr_recal_watch.sv
`timescale 1ns/100ps
// counts recalibrate steps and flags a drive that never reports track zero
module frsr_recal_watch
    import frsr_pkg::*;
#(
    parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
    input  wire logic i_clock,
    input  wire logic i_resetn,
    input  wire logic i_recal_start,
    input  wire logic i_step_pulse,
    input  wire logic i_track_zero,
    output logic      o_fault
);
    logic [7:0] steps_ff;
    logic       active_ff;
    logic       fault_ff;
    logic       limit_hit;

    assign limit_hit = (steps_ff == 8'(STEP_LIMIT));

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            steps_ff  <= 8'h00;
            active_ff <= 1'b0;
            fault_ff  <= 1'b0;
        end else if (i_recal_start) begin
            steps_ff  <= 8'h00;
            active_ff <= 1'b1;
            fault_ff  <= 1'b0;
        end else if (active_ff) begin
            if (i_track_zero) begin
                active_ff <= 1'b0;
            end else if (limit_hit) begin
                active_ff <= 1'b0;
                fault_ff  <= 1'b1; // [R17]
            end else if (i_step_pulse) begin
                steps_ff <= steps_ff + 8'h01;
            end
        end
    end

    assign o_fault = fault_ff;
endmodule : frsr_recal_watch

// file: design/frsr_regs.sv
`timescale 1ns/100ps
// rate/configuration write register, input status read register and
// first result status byte of the floppy controller host port
module frsr_regs
    import frsr_pkg::*;
#(
    parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
    input  wire logic       i_clock,
    input  wire logic       i_resetn,
    // software reset from the output or rate control registers
    input  wire logic       i_soft_reset,
    // compatibility layout, from configuration outside this block
    input  wire logic [1:0] i_compat_mode,
    // host i/o port
    input  wire logic [9:0] i_io_addr,
    input  wire logic       i_io_rd,
    input  wire logic       i_io_wr,
    input  wire logic [7:0] i_io_wdata,
    output logic      [7:0] o_io_rdata,
    output logic            o_io_rvalid,
    // drive cable, active-low change line and track zero
    input  wire logic       i_media_changed_n,
    input  wire logic       i_track_zero_pin,
    // runtime force-change register
    input  wire logic       i_force_change_en,
    input  wire logic       i_force_change_val,
    // gate bit of the output control register
    input  wire logic       i_transfer_gate_on,
    // command engine
    input  wire logic       i_result_phase,
    input  wire logic       i_cmd_done,
    input  wire logic [1:0] i_termination_code,
    input  wire logic       i_seek_complete,
    input  wire logic       i_recal_start,
    input  wire logic       i_step_pulse,
    input  wire logic       i_outward_past_zero,
    input  wire logic       i_head,
    input  wire logic [1:0] i_unit_number,
    // outputs to the data path and drive
    output logic      [1:0] o_rate_pick,
    output logic            o_skip_precomp_flag,
    output logic            o_density_pin,
    output logic      [7:0] o_status_zero
);

    // synchronised cable pins
    logic       media_changed_n_s;
    logic       track_zero_s;

    // stored state
    logic [1:0] rate_ff;
    logic       precomp_ff;
    logic       density_ff;
    logic [7:0] status_zero_ff;
    logic       seek_done_ff;
    logic [7:0] rdata_ff;
    logic       rvalid_ff;

    // next values
    logic [1:0] nxt_rate;
    logic       nxt_precomp;
    logic       nxt_density;
    logic [7:0] nxt_status_zero;
    logic       nxt_seek_done;
    logic [7:0] nxt_rdata;

    // decode and selection
    frsr_mode_t mode;
    logic       hit_input_config;
    logic       hit_data;
    logic       cfg_write;
    logic       input_read;
    logic       status_read;
    logic       media_changed;
    logic       slow_rate_flag;
    logic       fast_rate;
    logic       recal_fault;
    logic       drive_fault;
    logic [7:0] input_at;
    logic [7:0] input_second_gen;
    logic [7:0] input_model30;
    logic [7:0] input_view;
    logic [7:0] status_view;

    frsr_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .i_clock  (i_clock),
        .i_resetn (i_resetn),
        .i_async  ({i_media_changed_n, i_track_zero_pin}),
        .o_sync   ({media_changed_n_s, track_zero_s})
    );

    frsr_recal_watch #(
        .STEP_LIMIT (STEP_LIMIT)
    ) u_recal_watch (
        .i_clock       (i_clock),
        .i_resetn      (i_resetn),
        .i_recal_start (i_recal_start),
        .i_step_pulse  (i_step_pulse),
        .i_track_zero  (track_zero_s),
        .o_fault       (recal_fault)
    );

    // address decode
    assign mode             = frsr_mode_t'(i_compat_mode); // [R20]
    assign hit_input_config = (i_io_addr == ADDR_INPUT_CONFIG);
    assign hit_data         = (i_io_addr == ADDR_DATA);
    assign cfg_write        = i_io_wr && hit_input_config; // [R10]
    assign input_read       = i_io_rd && hit_input_config;
    assign status_read      = i_io_rd && hit_data && i_result_phase;

    // change indication: cable line is active low, forcing overrides it
    assign media_changed = i_force_change_en ? i_force_change_val
                                             : !media_changed_n_s; // [R3]

    // fast rates are 500K and 1M
    assign fast_rate      = (rate_ff == RATE_500K) || (rate_ff == RATE_1M); // [R21]
    assign slow_rate_flag = !fast_rate; // [R4]

    // three input register layouts
    assign input_at = {media_changed, 7'h00}; // [R2] [R3]

    assign input_second_gen = {
        media_changed,
        SECOND_GEN_ONES,
        rate_ff,
        slow_rate_flag
    }; // [R4] [R6]

    assign input_model30 = {
        media_changed,
        3'h0,
        i_transfer_gate_on,
        precomp_ff,
        rate_ff
    }; // [R7] [R8] [R9]

    // the spare mode code falls back to the AT layout
    always_comb begin
        unique case (mode)
            FRSR_MODE_SECOND_GEN: input_view = input_second_gen;
            FRSR_MODE_MODEL30:    input_view = input_model30;
            FRSR_MODE_AT:         input_view = input_at;
            FRSR_MODE_SPARE:      input_view = input_at;
        endcase
    end

    // result byte zero, bit 3 hard zero
    assign drive_fault = recal_fault || i_outward_past_zero; // [R17]

    assign status_view = {
        i_termination_code,
        seek_done_ff,
        drive_fault,
        1'b0,
        i_head,
        i_unit_number
    }; // [R15] [R16] [R18] [R19]

    // rate bits: writes only, the soft reset leaves them alone
    always_comb begin
        nxt_rate = rate_ff;
        if (cfg_write) begin
            nxt_rate = i_io_wdata[1:0]; // [R10] [R5]
        end
    end

    // precompensation bit is stored in model-30 mode only;
    // elsewhere bit 2 is reserved and ignored
    always_comb begin
        nxt_precomp = precomp_ff;
        if (cfg_write && (mode == FRSR_MODE_MODEL30)) begin
            nxt_precomp = i_io_wdata[BIT_PRECOMP]; // [R12]
        end
    end

    // density follows the written rate; only hard reset forces it high
    always_comb begin
        nxt_density = density_ff;
        if (cfg_write) begin
            nxt_density = (i_io_wdata[1:0] == RATE_500K) ||
                          (i_io_wdata[1:0] == RATE_1M); // [R13]
        end
    end

    // seek-end event is sticky until the result byte is read or a soft reset;
    // an event in a clearing cycle wins so it is not lost
    always_comb begin
        nxt_seek_done = seek_done_ff;
        if (i_seek_complete) begin
            nxt_seek_done = 1'b1; // [R16]
        end else if (i_soft_reset || status_read) begin
            nxt_seek_done = 1'b0;
        end
    end

    // result byte is frozen at command end for the result phase
    always_comb begin
        nxt_status_zero = status_zero_ff;
        if (i_soft_reset) begin
            nxt_status_zero = 8'h00;
        end else if (i_cmd_done) begin
            nxt_status_zero = status_view; // [R14]
        end
    end

    // read data; reads have no side effect on the configuration
    always_comb begin
        nxt_rdata = READ_IDLE;
        if (input_read) begin
            nxt_rdata = input_view; // [R1]
        end else if (status_read) begin
            nxt_rdata = status_zero_ff; // [R14]
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rate_ff    <= RATE_RESET; // [R5] [R9] [R10]
            precomp_ff <= PRECOMP_RESET;
            density_ff <= DENSITY_RESET; // [R13]
        end else begin
            rate_ff    <= nxt_rate;
            precomp_ff <= nxt_precomp;
            density_ff <= nxt_density;
        end
    end

    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            status_zero_ff <= 8'h00;
            seek_done_ff   <= 1'b0;
        end else begin
            status_zero_ff <= nxt_status_zero;
            seek_done_ff   <= nxt_seek_done;
        end
    end

    // read answer arrives one cycle after the strobe
    always_ff @(posedge i_clock or negedge i_resetn) begin
        if (!i_resetn) begin
            rdata_ff  <= READ_IDLE;
            rvalid_ff <= 1'b0;
        end else begin
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= input_read || status_read;
        end
    end

    assign o_io_rdata          = rdata_ff;
    assign o_io_rvalid         = rvalid_ff;
    assign o_rate_pick         = rate_ff;
    assign o_skip_precomp_flag = precomp_ff;
    assign o_density_pin       = density_ff;
    assign o_status_zero       = status_zero_ff;

endmodule : frsr_regs

// file: dv/frsr_regs_sva.sv
`timescale 1ns/100ps
module frsr_regs_sva
    import frsr_pkg::*;
#(
    parameter int STEP_LIMIT = RECAL_STEP_LIMIT
) (
    input wire logic       i_clock,
    input wire logic       i_resetn,
    input wire logic       i_soft_reset,
    input wire logic [1:0] i_compat_mode,
    input wire logic [9:0] i_io_addr,
    input wire logic       i_io_rd,
    input wire logic       i_io_wr,
    input wire logic [7:0] i_io_wdata,
    input wire logic [7:0] o_io_rdata,
    input wire logic       o_io_rvalid,
    input wire logic       i_force_change_en,
    input wire logic       i_force_change_val,
    input wire logic       i_transfer_gate_on,
    input wire logic       i_cmd_done,
    input wire logic [1:0] i_termination_code,
    input wire logic       i_head,
    input wire logic [1:0] i_unit_number,
    input wire logic [1:0] o_rate_pick,
    input wire logic       o_skip_precomp_flag,
    input wire logic       o_density_pin,
    input wire logic [7:0] o_status_zero
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_resetn);
    wire rd_hit = i_io_rd && i_io_addr == ADDR_INPUT_CONFIG;
    wire wr_hit = i_io_wr && i_io_addr == ADDR_INPUT_CONFIG;
    wire rd_off = i_io_rd && i_io_addr != ADDR_INPUT_CONFIG && i_io_addr != ADDR_DATA;
    property p_read_ans;
        rd_hit && !i_io_wr |=> o_io_rvalid && $stable(o_rate_pick);
    endproperty
    a_read_ans: assert property (p_read_ans) else $error("read answer or state wrong");
    property p_no_ans;
        rd_off |=> !o_io_rvalid && o_io_rdata == READ_IDLE;
    endproperty
    a_no_ans: assert property (p_no_ans) else $error("unmapped read answered");
    property p_at;
        rd_hit && i_compat_mode == 2'h0 |=> o_io_rdata[6:0] == 7'h00;
    endproperty
    a_at: assert property (p_at) else $error("at layout low bits set");
    property p_force;
        rd_hit && i_force_change_en |=> o_io_rdata[BIT_CHANGE] == $past(i_force_change_val);
    endproperty
    a_force: assert property (p_force) else $error("forced change bit wrong");
    property p_second;
        rd_hit && i_compat_mode == 2'h1 |=>
            o_io_rdata[6:0] == {4'hF, $past(o_rate_pick), ^$past(o_rate_pick)};
    endproperty
    a_second: assert property (p_second) else $error("second-gen layout wrong");
    property p_m30;
        rd_hit && i_compat_mode == 2'h2 |=> o_io_rdata[6:0] ==
            {3'h0, $past(i_transfer_gate_on), $past(o_skip_precomp_flag), $past(o_rate_pick)};
    endproperty
    a_m30: assert property (p_m30) else $error("model-30 layout wrong");
    property p_write;
        wr_hit |=> o_rate_pick == $past(i_io_wdata[1:0]);
    endproperty
    a_write: assert property (p_write) else $error("rate write not taken");
    property p_soft;
        i_soft_reset && !wr_hit |=>
            $stable(o_rate_pick) && $stable(o_skip_precomp_flag) && $stable(o_density_pin);
    endproperty
    a_soft: assert property (p_soft) else $error("soft reset disturbed state");
    property p_code;
        i_cmd_done |=> o_status_zero[7:6] == $past(i_termination_code);
    endproperty
    a_code: assert property (p_code) else $error("termination code wrong");
    property p_unit;
        i_cmd_done |=> o_status_zero[3:0] == {1'b0, $past(i_head), $past(i_unit_number)};
    endproperty
    a_unit: assert property (p_unit) else $error("head or unit wrong");
endmodule : frsr_regs_sva
bind frsr_regs frsr_regs_sva #(.STEP_LIMIT(STEP_LIMIT)) i_sva (
    .i_clock(i_clock), .i_resetn(i_resetn), .i_soft_reset(i_soft_reset),
    .i_compat_mode(i_compat_mode), .i_io_addr(i_io_addr), .i_io_rd(i_io_rd),
    .i_io_wr(i_io_wr), .i_io_wdata(i_io_wdata), .o_io_rdata(o_io_rdata),
    .o_io_rvalid(o_io_rvalid), .i_force_change_en(i_force_change_en),
    .i_force_change_val(i_force_change_val), .i_transfer_gate_on(i_transfer_gate_on),
    .i_cmd_done(i_cmd_done), .i_termination_code(i_termination_code), .i_head(i_head),
    .i_unit_number(i_unit_number), .o_rate_pick(o_rate_pick),
    .o_skip_precomp_flag(o_skip_precomp_flag), .o_density_pin(o_density_pin),
    .o_status_zero(o_status_zero));

// file: dv/frsr_host.sv
`timescale 1ns/100ps
// host side of the i/o port; one strobe per access, launched at the falling edge
module frsr_host (
    input  wire logic       i_clock,
    output logic      [9:0] o_io_addr,
    output logic            o_io_rd,
    output logic            o_io_wr,
    output logic      [7:0] o_io_wdata,
    input  wire logic [7:0] i_io_rdata,
    input  wire logic       i_io_rvalid
);
    initial begin
        o_io_addr = 10'h000;
        o_io_rd = 1'b0;
        o_io_wr = 1'b0;
        o_io_wdata = 8'hA5;
    end
    task automatic wr_cfg(input logic [2:0] d);
        @(negedge i_clock);
        o_io_addr = 10'h3F7;
        o_io_wdata = {5'h00, d};
        o_io_wr = 1'b1;
        @(negedge i_clock);
        o_io_wr = 1'b0;
        // released data lines do not keep the last value
        o_io_wdata = ~o_io_wdata;
        o_io_addr = 10'h000;
    endtask : wr_cfg
    task automatic rd_reg(input logic [9:0] a, output logic [7:0] d, output logic ok);
        @(negedge i_clock);
        o_io_addr = a;
        o_io_rd = 1'b1;
        @(negedge i_clock);
        o_io_rd = 1'b0;
        o_io_addr = 10'h000;
        d = i_io_rdata;
        ok = i_io_rvalid;
    endtask : rd_reg
endmodule : frsr_host

// file: dv/testbench.sv
`timescale 1ns/100ps
module testbench
    import frsr_pkg::*;
;
    logic       clock = 1'b0, resetn = 1'b0, soft_reset = 1'b0, chg_n = 1'b1;
    logic       fen = 1'b0, fval = 1'b0, gate = 1'b0, rph = 1'b0, done = 1'b0;
    logic       seek = 1'b0, head = 1'b0, rvalid, prec, dens, ok, m_prec = 1'b0;
    logic [1:0] mode = 2'h0, term = 2'h0, unit = 2'h0, rate, m_rate = 2'h2;
    logic [9:0] addr;
    logic       rd, wr;
    logic [7:0] wdata, rdata, st0, got, exp_st;
    logic [15:0] seed = 16'h8C01;
    logic       recal = 1'b0, step = 1'b0, past0 = 1'b0, track_zero_pin = 1'b0;
    localparam int STEPS = 4;
    int         failures = 0, n_checks = 0, cycles = 0;
    always #4 clock = ~clock;
    frsr_host i_host (.i_clock(clock), .o_io_addr(addr), .o_io_rd(rd), .o_io_wr(wr),
        .o_io_wdata(wdata), .i_io_rdata(rdata), .i_io_rvalid(rvalid));
    frsr_regs #(.STEP_LIMIT(STEPS)) i_dut (.i_clock(clock), .i_resetn(resetn),
        .i_soft_reset(soft_reset), .i_compat_mode(mode), .i_io_addr(addr), .i_io_rd(rd),
        .i_io_wr(wr), .i_io_wdata(wdata), .o_io_rdata(rdata), .o_io_rvalid(rvalid),
        .i_media_changed_n(chg_n), .i_track_zero_pin(track_zero_pin), .i_force_change_en(fen),
        .i_force_change_val(fval), .i_transfer_gate_on(gate), .i_result_phase(rph),
        .i_cmd_done(done), .i_termination_code(term), .i_seek_complete(seek),
        .i_recal_start(recal), .i_step_pulse(step), .i_outward_past_zero(past0),
        .i_head(head), .i_unit_number(unit), .o_rate_pick(rate),
        .o_skip_precomp_flag(prec), .o_density_pin(dens), .o_status_zero(st0));
    function automatic logic [15:0] lfsr(input logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    function automatic logic [7:0] exp_dir(input logic [1:0] r, input logic p);
        logic c;
        c = fen ? fval : ~chg_n;
        case (mode)
            2'h1: return {c, 4'hF, r, r[1] ^ r[0]};
            2'h2: return {c, 3'h0, gate, p, r};
            default: return {c, 7'h00};
        endcase
    endfunction : exp_dir
    task automatic check(input string name, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s exp %h got %h", name, e, g);
        end
    endtask : check
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim
    task automatic chk_dir();
        i_host.rd_reg(ADDR_INPUT_CONFIG, got, ok);
        check("rvalid", 8'h01, {7'h00, ok});
        check("dir", exp_dir(m_rate, m_prec), got);
        check("rate", {6'h00, m_rate}, {6'h00, rate});
        check("prec", {7'h00, m_prec}, {7'h00, prec});
    endtask : chk_dir
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            failures++;
            end_sim();
        end
    end
    initial begin
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        repeat (3) @(negedge clock);
        check("density", 8'h01, {7'h00, dens});
        for (int m = 0; m < 4; m++) begin
            mode = m[1:0];
            chk_dir();
        end
        i_host.rd_reg(10'h3F6, got, ok);
        check("unmapped", 8'h00, got);
        check("unmapped valid", 8'h00, {7'h00, ok});
        // data port outside the result phase gives no answer
        i_host.rd_reg(ADDR_DATA, got, ok);
        check("idle data", 8'h00, got);
        check("idle data valid", 8'h00, {7'h00, ok});
        $display("reset test done");
        for (int i = 0; i < 40; i++) begin
            seed = lfsr(seed);
            {m_rate, chg_n, fval, fen, gate, mode} = seed[7:0];
            if (mode == 2'h2) m_prec = seed[8];
            i_host.wr_cfg({mode == 2'h2 && seed[8], m_rate});
            repeat (3) @(negedge clock);
            chk_dir();
            check("density", {7'h00, ~(m_rate[1] ^ m_rate[0])}, {7'h00, dens});
            if (seed[9]) begin
                soft_reset = 1'b1;
                @(negedge clock);
                soft_reset = 1'b0;
                chk_dir();
                check("density", {7'h00, ~(m_rate[1] ^ m_rate[0])}, {7'h00, dens});
            end
        end
        $display("random test done");
        // hard reset in mid-run must undo a slow rate and a set precomp bit
        mode = 2'h2;
        i_host.wr_cfg(3'h5);
        check("density low", 8'h00, {7'h00, dens});
        resetn = 1'b0;
        repeat (2) @(negedge clock);
        resetn = 1'b1;
        {m_rate, m_prec} = {RATE_RESET, PRECOMP_RESET};
        repeat (3) @(negedge clock);
        check("density", 8'h01, {7'h00, dens});
        chk_dir();
        $display("hard reset test done");
        rph = 1'b1;
        for (int t = 0; t < 4; t++) begin
            seed = lfsr(seed);
            {head, unit, term} = {seed[2:0], t[1:0]};
            // track zero stays away in the first two passes, so the step limit trips
            track_zero_pin = t[1];
            past0 = (t == 2);
            recal = 1'b1;
            @(negedge clock);
            recal = 1'b0;
            repeat (STEPS) begin
                step = 1'b1;
                @(negedge clock);
                step = 1'b0;
                @(negedge clock);
            end
            seek = t[0];
            @(negedge clock);
            seek = 1'b0;
            done = 1'b1;
            @(negedge clock);
            done = 1'b0;
            past0 = 1'b0;
            exp_st = {term, t[0], ~t[1] | (t == 2), 1'b0, head, unit};
            check("status", exp_st, st0);
            i_host.rd_reg(ADDR_DATA, got, ok);
            check("status read", exp_st, got);
        end
        $display("status test done");
        end_sim();
    end
endmodule : testbench
